// ===== dv/core_model.sv
// model of the processor core side: special-function register reads and writes.
// assumes: tasks are entered just after a falling clock edge.
`timescale 1ns/1ps
module core_model (
   input wire REF_CLK, // system clock
   input wire CPU_HOLD, // core stall
   input wire [7:0] SFR_RDATA, // read data
   output reg [7:0] SFR_ADDR, // register address
   output reg SFR_WR, // write strobe
   output reg [7:0] SFR_WDATA // write data
);
   integer timeouts;
   initial begin
      SFR_ADDR = 8'h00;
      SFR_WR = 1'b0;
      SFR_WDATA = 8'h00;
      timeouts = 0;
   end
   // a stalled core issues nothing, so wait for the stall to end
   task wait_run;
      integer k;
      begin
         for (k = 0; k < 20000 && CPU_HOLD !== 1'b0; k = k + 1) @(negedge REF_CLK);
         if (CPU_HOLD !== 1'b0) timeouts = timeouts + 1;
      end
   endtask
   // one idle edge first, so back-to-back writes never touch the strobe twice in a step
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge REF_CLK);
         wait_run;
         SFR_ADDR = a;
         SFR_WDATA = d;
         SFR_WR = 1'b1;
         @(negedge REF_CLK);
         SFR_WR = 1'b0;
         SFR_WDATA = ~d;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         wait_run;
         SFR_ADDR = a;
         @(negedge REF_CLK);
         d = SFR_RDATA;
      end
   endtask
endmodule // core_model

// ===== dv/flash_command_controller_monitor.sv
// checker for the flash command controller, bound to its top module.
// assumes: single clock REF_CLK, synchronous active-high RST.
`timescale 1ns/1ps
module flash_command_controller_monitor #(
   parameter ARRAY_BYTES = 16384 // matches the design
) (
   input wire REF_CLK, // system clock
   input wire RST, // sync reset
   input wire [7:0] SFR_ADDR, // register address
   input wire SFR_WR, // write strobe
   input wire [7:0] SFR_WDATA, // write data
   input wire [7:0] SFR_RDATA, // read data
   input wire SFR_HIT, // address hit
   input wire CPU_HOLD, // core stall
   input wire IRQ_HOLD // interrupt defer
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   reg [7:0] key_ff;
   integer hold_cnt_ff;
   function automatic logic is_mapped(input logic [7:0] a);
      return (a >= 8'hb9 && a <= 8'hbf) || a == 8'hc6 || a == 8'hc7;
   endfunction
   // mirror of the unlock key; any command write clears it
   always @(posedge REF_CLK) begin
      if (RST) key_ff <= 8'hff;
      else if (SFR_WR && !CPU_HOLD && SFR_ADDR == 8'hba) key_ff <= SFR_WDATA;
      else if (SFR_WR && !CPU_HOLD && SFR_ADDR == 8'hb9) key_ff <= 8'hff;
   end
   always @(posedge REF_CLK) begin
      if (RST || !CPU_HOLD) hold_cnt_ff <= 0;
      else hold_cnt_ff <= hold_cnt_ff + 1;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   AST_IRQ_TRACKS: assert property (IRQ_HOLD == CPU_HOLD)
      else $error("interrupt defer differs from core stall");
   AST_HIT_DECODE: assert property (!RST |=> SFR_HIT == is_mapped($past(SFR_ADDR)))
      else $error("address hit does not match decode");
   AST_HOLD_CAUSE: assert property ($rose(CPU_HOLD) |->
      $past(SFR_WR) && $past(SFR_ADDR) == 8'hb9)
      else $error("stall without a command write");
   AST_NO_KEY: assert property (SFR_WR && !CPU_HOLD && SFR_ADDR == 8'hb9 &&
      key_ff != 8'h3b |=> !CPU_HOLD [*2])
      else $error("command ran without unlock key");
   AST_HOLD_MIN: assert property ($rose(CPU_HOLD) |-> CPU_HOLD [*3])
      else $error("stall shorter than three cycles");
   AST_HOLD_BOUND: assert property (CPU_HOLD |-> hold_cnt_ff <= ARRAY_BYTES + 2)
      else $error("stall too long");
   AST_READ_FOLLOWS: assert property ((SFR_WR && !CPU_HOLD && SFR_ADDR == 8'hbc)
      ##1 (SFR_ADDR == 8'hbc && !SFR_WR) |=> SFR_RDATA == $past(SFR_WDATA, 2))
      else $error("data register read back wrong");
   AST_BOOT_HOLD: assert property ($fell(RST) |-> CPU_HOLD [*6])
      else $error("core released before protection load");
endmodule // flash_command_controller_monitor

// ===== dv/testbench.sv
// self-checking bench for the flash command controller.
// assumes: core_model drives the register port; stalls are counted per command.
`timescale 1ns/1ps
module testbench;
   reg REF_CLK;
   reg RST;
   wire [7:0] sfr_addr;
   wire sfr_wr;
   wire [7:0] sfr_wdata;
   wire [7:0] sfr_rdata;
   wire sfr_hit;
   wire cpu_hold;
   wire irq_hold;
   integer num_errors;
   integer samples_checked;
   integer i;
   reg [7:0] v;
   reg [7:0] rst_tab [0:9];
   reg [7:0] adr_tab [0:9];
   flash_command_controller flash_command_controller_i (.REF_CLK(REF_CLK), .RST(RST),
      .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
      .SFR_HIT(sfr_hit), .CPU_HOLD(cpu_hold), .IRQ_HOLD(irq_hold));
   core_model core_model_i (.REF_CLK(REF_CLK), .CPU_HOLD(cpu_hold), .SFR_RDATA(sfr_rdata),
      .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata));
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end
   // a core that never sees the stall end closes the run
   always @(negedge REF_CLK) begin
      if (core_model_i.timeouts != 0) finish_test;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task finish_test;
      begin
         num_errors = num_errors + core_model_i.timeouts;
         if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e, input string name);
      begin
         core_model_i.rd(a, v);
         check(name, {8'h00, v}, {8'h00, e});
      end
   endtask
   task setup(input [15:0] a, input [7:0] d);
      begin
         core_model_i.wr(8'hc7, a[15:8]);
         core_model_i.wr(8'hc6, a[7:0]);
         core_model_i.wr(8'hbc, d);
      end
   endtask
   // key, command, then count stalled cycles; a refusal never stalls
   task op(input [7:0] key, input [7:0] code, input [15:0] len);
      integer k;
      integer n;
      integer m;
      begin
         n = 0;
         m = 0;
         core_model_i.wr(8'hba, key);
         core_model_i.wr(8'hb9, code);
         for (k = 0; k < 20000; k = k + 1) begin
            if (irq_hold === 1'b1) m = m + 1;
            if (cpu_hold === 1'b1) n = n + 1;
            else if (n > 0 || k > 3) break;
            @(negedge REF_CLK);
         end
         if (k == 20000) begin
            num_errors = num_errors + 1;
            finish_test;
         end else begin
            check("stall length", n[15:0], len);
            check("interrupt defer length", m[15:0], len);
         end
      end
   endtask
   task flash_rd(input [15:0] a, input [7:0] e);
      begin
         setup(a, 8'h00);
         op(8'h3b, 8'h04, 16'd3);
         rd_chk(8'hbc, e, "flash byte");
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      num_errors = 0;
      samples_checked = 0;
      RST = 1'b1;
      rst_tab = '{8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      adr_tab = '{8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc6, 8'hc7, 8'h50};
      repeat (10) @(negedge REF_CLK);
      RST = 1'b0;
      for (i = 0; i < 10; i = i + 1) rd_chk(adr_tab[i], rst_tab[i], "reset value");
      check("unmapped hit", {15'h0000, sfr_hit}, 16'h0000);
      core_model_i.wr(8'hbc, 8'h77);
      rd_chk(8'hbc, 8'h77, "data register");
      check("mapped hit", {15'h0000, sfr_hit}, 16'h0001);
      // program, then read back through the read command
      setup(16'h0405, 8'h5a);
      op(8'h3b, 8'h01, 16'd3);
      rd_chk(8'hba, 8'hff, "key after op");
      flash_rd(16'h0405, 8'h5a);
      // programming only clears bits
      setup(16'h0405, 8'h0f);
      op(8'h3b, 8'h01, 16'd3);
      flash_rd(16'h0405, 8'h0a);
      // wrong key and unknown code change nothing and do not stall
      setup(16'h0405, 8'h66);
      op(8'h12, 8'h04, 16'd0);
      rd_chk(8'hbc, 8'h66, "data after bad key");
      op(8'h3b, 8'h06, 16'd0);
      rd_chk(8'hbc, 8'h66, "data after bad code");
      rd_chk(8'hba, 8'hff, "key after bad code");
      flash_rd(16'h0405, 8'h0a);
      // page erase by any address in the page
      setup(16'h05ff, 8'h00);
      op(8'h3b, 8'h02, 16'd513);
      flash_rd(16'h0405, 8'hff);
      // erase page then program
      setup(16'h0600, 8'h33);
      op(8'h3b, 8'h05, 16'd515);
      flash_rd(16'h0600, 8'h33);
      // whole-array erase while no protection is active
      op(8'h3b, 8'h03, 16'd16385);
      flash_rd(16'h0600, 8'hff);
      // stored key is blank, so the first protect command takes the key
      core_model_i.wr(8'hbb, 8'h5a);
      setup(16'hffff, 8'h00);
      op(8'h3b, 8'h08, 16'd13);
      flash_rd(16'h3ffa, 8'h5a);
      // mismatching protection key is refused
      core_model_i.wr(8'hbb, 8'h11);
      setup(16'hffff, 8'h00);
      op(8'h3b, 8'h08, 16'd0);
      flash_rd(16'h3ffa, 8'h5a);
      // protect page 0 and read group 0, and guard page 31 so protection is live
      core_model_i.wr(8'hbb, 8'h5a);
      core_model_i.wr(8'hbd, 8'hfe);
      core_model_i.wr(8'hbf, 8'hfe);
      setup(16'h7fff, 8'h00);
      op(8'h3b, 8'h08, 16'd13);
      setup(16'h0010, 8'h44);
      op(8'h3b, 8'h01, 16'd0);
      op(8'h3b, 8'h02, 16'd0);
      op(8'h3b, 8'h04, 16'd0);
      rd_chk(8'hbc, 8'h44, "data after read block");
      op(8'h3b, 8'h03, 16'd0);
      flash_rd(16'h3ffa, 8'h5a);
      flash_rd(16'h0810, 8'hff);
      finish_test;
   end
endmodule // testbench

bind flash_command_controller flash_command_controller_monitor #(.ARRAY_BYTES(ARRAY_BYTES))
   flash_command_controller_monitor_i (.REF_CLK(REF_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR),
   .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
   .CPU_HOLD(CPU_HOLD), .IRQ_HOLD(IRQ_HOLD));

// ===== verilog/flash_command_controller.v
// flash_command_controller: flash array, its command sequencer and its registers.
// assumes: the core writes registers through the special-function port, one access
// per cycle, and stops issuing accesses while CPU_HOLD is high.

`timescale 1ns/1ps

`include "flash_map.vh"

module flash_command_controller #(
   parameter ARRAY_BYTES = `FM_ARRAY_BYTES // bytes in the array, one erase step each
) (
   input wire REF_CLK, // 50 MHz system clock
   input wire RST, // synchronous reset, active high
   input wire [7:0] SFR_ADDR, // register address
   input wire SFR_WR, // write strobe, one cycle
   input wire [7:0] SFR_WDATA, // write data
   output reg [7:0] SFR_RDATA, // read data for last cycle's address
   output reg SFR_HIT, // last cycle's address was one of ours
   output reg CPU_HOLD, // hold the program counter
   output reg IRQ_HOLD // defer interrupt servicing
);

   // ------------------------------------------------------------
   // states and constants
   // ------------------------------------------------------------
   localparam S_BOOT = 3'd0;
   localparam S_IDLE = 3'd1;
   localparam S_ERASE = 3'd2;
   localparam S_PRD = 3'd3;
   localparam S_PWR = 3'd4;
   localparam S_RDA = 3'd5;
   localparam S_RDC = 3'd6;
   localparam S_DONE = 3'd7;

   localparam AW = `FM_ADDR_W;
   localparam PB = `FM_PAGE_BITS;
   localparam integer LAST_I = ARRAY_BYTES - 1;
   localparam [AW-1:0] LAST_ALL = LAST_I[AW-1:0];
   localparam [2:0] BOOT_END = `FM_PROT_LAST + 3'd1;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [2:0] state_ff;
   reg [AW-1:0] cnt_ff;
   reg [2:0] idx_ff;
   reg all_ff;
   reg then_prog_ff;
   reg prot_ff;
   reg keywr_ff;

   reg [7:0] cmd_ff;
   reg [7:0] key_ff;
   reg [7:0] pkey_ff;
   reg [7:0] data_ff;
   reg [7:0] wplo_ff;
   reg [7:0] wpmid_ff;
   reg [7:0] rprot_ff;
   reg [7:0] adrl_ff;
   reg [7:0] adrh_ff;

   reg [7:0] rd_ff;
   reg [7:0] mem [0:ARRAY_BYTES-1];
   integer i;

   // ------------------------------------------------------------
   // address and protection view
   // ------------------------------------------------------------
   wire [15:0] adr16 = {adrh_ff, adrl_ff};
   wire [AW-1:0] faddr = adr16[AW-1:0]; // R2
   wire [4:0] page = faddr[AW-1:PB]; // R1

   wire [47:0] sh;
   wire [7:0] stored_key = sh[7:0];
   wire [7:0] rd_bits = sh[15:8];
   wire [31:0] we_bits = sh[47:16];

   // page and read protection are enforced only while page 31 guards itself; the protection key check always applies
   wire active = ~we_bits[31]; // R20
   wire page_blk = active & ~we_bits[page]; // R22
   wire read_blk = active & ~rd_bits[page[4:2]]; // R21

   wire [AW-1:0] prot_addr = `FM_PROT_BASE + {11'h000, idx_ff};
   wire [2:0] cap_idx = idx_ff - 3'd1;
   wire boot_cap = (state_ff == S_BOOT) && (idx_ff != 3'd0);

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire cmd_wr = SFR_WR && (SFR_ADDR == `FM_CMD_ADDR) && (state_ff == S_IDLE);
   wire key_ok = (key_ff == `FM_UNLOCK_KEY); // R3
   wire key_free = (stored_key == `FM_ONES_RST); // R16
   wire prot_go = key_free || (stored_key == pkey_ff); // R15

   reg go;
   always @* begin
      case (SFR_WDATA)
         `FM_OP_PROG: go = ~page_blk; // R22
         `FM_OP_ERPAGE: go = ~page_blk; // R22
         `FM_OP_ERALL: go = ~active; // R20
         `FM_OP_READ: go = ~read_blk; // R21
         `FM_OP_ERPROG: go = ~page_blk; // R22
         `FM_OP_PROT: go = prot_go; // R15
         default: go = 1'b0; // R23
      endcase
   end

   // rejected commands fall through without a stall
   wire accept = cmd_wr && key_ok && go; // R24

   // ------------------------------------------------------------
   // bytes committed by the protect command
   // ------------------------------------------------------------
   // the high and low address registers double as the upper write/erase bits,
   // so a protect command cannot also carry a meaningful address
   reg [7:0] prot_byte;
   always @* begin
      case (idx_ff)
         3'd0: prot_byte = keywr_ff ? pkey_ff : `FM_ERASED; // R17
         3'd1: prot_byte = rprot_ff; // R14
         3'd2: prot_byte = wplo_ff;
         3'd3: prot_byte = wpmid_ff;
         3'd4: prot_byte = adrl_ff;
         3'd5: prot_byte = adrh_ff;
         default: prot_byte = `FM_ERASED;
      endcase
   end

   wire [AW-1:0] op_addr = prot_ff ? prot_addr : faddr;
   wire [7:0] op_data = prot_ff ? prot_byte : data_ff;

   // ------------------------------------------------------------
   // array port
   // ------------------------------------------------------------
   reg [AW-1:0] m_addr;
   reg m_we;
   reg [7:0] m_wd;
   always @* begin
      m_addr = faddr;
      m_we = 1'b0;
      m_wd = `FM_ERASED;
      case (state_ff)
         S_BOOT: begin
            m_addr = prot_addr;
         end
         S_ERASE: begin
            m_addr = all_ff ? cnt_ff : {page, cnt_ff[PB-1:0]}; // R1
            m_we = 1'b1;
            m_wd = `FM_ERASED; // R19
         end
         S_PRD: begin
            m_addr = op_addr;
         end
         S_PWR: begin
            m_addr = op_addr;
            m_we = 1'b1;
            // programming can only clear bits
            m_wd = rd_ff & op_data; // R19
         end
         default: begin
            m_addr = faddr;
         end
      endcase
   end

   // array starts erased; it is not cleared by reset, like real flash
   initial begin
      for (i = 0; i < ARRAY_BYTES; i = i + 1) begin
         mem[i] = `FM_ERASED; // R19
      end
   end

   always @(posedge REF_CLK) begin
      if (m_we) begin
         mem[m_addr] <= m_wd;
      end
      rd_ff <= mem[m_addr];
   end

   // ------------------------------------------------------------
   // shadow of the protection bytes
   // ------------------------------------------------------------
   // kept in flops so the checks need no extra array read; refreshed at boot
   // and on every array write that lands on one of the six bytes
   genvar g;
   generate
      for (g = 0; g < `FM_PROT_BYTES; g = g + 1) begin : g_shadow
         localparam integer GI = g;
         localparam [AW-1:0] SADDR = `FM_PROT_BASE + GI[AW-1:0];
         localparam [2:0] SIDX = GI[2:0];
         reg [7:0] byte_ff;
         always @(posedge REF_CLK) begin
            if (RST) begin
               byte_ff <= `FM_ONES_RST;
            end else if (m_we && (m_addr == SADDR)) begin
               byte_ff <= m_wd;
            end else if (boot_cap && (cap_idx == SIDX)) begin
               byte_ff <= rd_ff;
            end
         end
         assign sh[8*g+7:8*g] = byte_ff;
      end
   endgenerate

   // ------------------------------------------------------------
   // sequencer and registers
   // ------------------------------------------------------------
   always @(posedge REF_CLK) begin
      if (RST) begin
         state_ff <= S_BOOT;
         cnt_ff <= {AW{1'b0}};
         idx_ff <= 3'd0;
         all_ff <= 1'b0;
         then_prog_ff <= 1'b0;
         prot_ff <= 1'b0;
         keywr_ff <= 1'b0;
         cmd_ff <= `FM_ZERO_RST; // R18
         key_ff <= `FM_ONES_RST;
         pkey_ff <= `FM_ONES_RST;
         data_ff <= `FM_ZERO_RST;
         wplo_ff <= `FM_ONES_RST;
         wpmid_ff <= `FM_ONES_RST;
         rprot_ff <= `FM_ONES_RST;
         adrl_ff <= `FM_ZERO_RST;
         adrh_ff <= `FM_ZERO_RST;
         CPU_HOLD <= 1'b1;
         IRQ_HOLD <= 1'b1;
      end else begin
         case (state_ff)
            S_BOOT: begin
               // core stays held while the protection bytes are fetched
               idx_ff <= idx_ff + 3'd1;
               if (idx_ff == BOOT_END) begin
                  idx_ff <= 3'd0;
                  state_ff <= S_IDLE;
                  CPU_HOLD <= 1'b0;
                  IRQ_HOLD <= 1'b0;
               end
            end
            S_IDLE: begin
               if (SFR_WR) begin
                  case (SFR_ADDR)
                     `FM_UNLOCK_ADDR: key_ff <= SFR_WDATA;
                     `FM_PKEY_ADDR: pkey_ff <= SFR_WDATA;
                     `FM_DATA_ADDR: data_ff <= SFR_WDATA;
                     `FM_WPLO_ADDR: wplo_ff <= SFR_WDATA;
                     `FM_WPMID_ADDR: wpmid_ff <= SFR_WDATA;
                     `FM_RPROT_ADDR: rprot_ff <= SFR_WDATA;
                     `FM_ADRL_ADDR: adrl_ff <= SFR_WDATA;
                     `FM_ADRH_ADDR: adrh_ff <= SFR_WDATA;
                     default: cmd_ff <= cmd_ff;
                  endcase
               end
               if (cmd_wr) begin
                  cmd_ff <= SFR_WDATA;
                  // every command write spends the key, accepted or not
                  key_ff <= `FM_ONES_RST; // R4
                  cnt_ff <= {AW{1'b0}};
                  idx_ff <= 3'd0;
                  all_ff <= 1'b0;
                  then_prog_ff <= 1'b0;
                  prot_ff <= 1'b0;
                  keywr_ff <= 1'b0;
               end
               if (accept) begin
                  CPU_HOLD <= 1'b1; // R5
                  IRQ_HOLD <= 1'b1; // R6
                  case (SFR_WDATA)
                     `FM_OP_PROG: state_ff <= S_PRD; // R8
                     `FM_OP_ERPAGE: state_ff <= S_ERASE; // R10
                     `FM_OP_ERALL: begin
                        all_ff <= 1'b1; // R11
                        state_ff <= S_ERASE;
                     end
                     `FM_OP_READ: state_ff <= S_RDA; // R12
                     `FM_OP_ERPROG: begin
                        then_prog_ff <= 1'b1; // R13
                        state_ff <= S_ERASE;
                     end
                     default: begin
                        prot_ff <= 1'b1; // R14
                        // key byte once erased takes the new key; after that
                        // it can only change by erasing page 31
                        keywr_ff <= key_free; // R17
                        state_ff <= S_PRD;
                     end
                  endcase
               end
            end
            S_ERASE: begin
               cnt_ff <= cnt_ff + {{(AW-1){1'b0}}, 1'b1};
               if (cnt_ff == (all_ff ? LAST_ALL : `FM_PAGE_LAST)) begin
                  cnt_ff <= {AW{1'b0}};
                  state_ff <= then_prog_ff ? S_PRD : S_DONE; // R13
               end
            end
            S_PRD: begin
               state_ff <= S_PWR;
            end
            S_PWR: begin
               if (prot_ff && (idx_ff != `FM_PROT_LAST)) begin
                  idx_ff <= idx_ff + 3'd1; // R14
                  state_ff <= S_PRD;
               end else begin
                  state_ff <= S_DONE;
               end
            end
            S_RDA: begin
               state_ff <= S_RDC;
            end
            S_RDC: begin
               data_ff <= rd_ff; // R12
               state_ff <= S_DONE;
            end
            default: begin
               // the core and interrupt servicing are released here; timers never stopped
               CPU_HOLD <= 1'b0; // R7
               IRQ_HOLD <= 1'b0; // R6
               key_ff <= `FM_ONES_RST; // R4
               prot_ff <= 1'b0;
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // register read-back
   // ------------------------------------------------------------
   // registered so the output comes from a flop; answer lags address by a cycle
   always @(posedge REF_CLK) begin
      if (RST) begin
         SFR_RDATA <= 8'h00;
         SFR_HIT <= 1'b0;
      end else begin
         SFR_HIT <= 1'b1;
         case (SFR_ADDR)
            `FM_CMD_ADDR: SFR_RDATA <= cmd_ff;
            `FM_UNLOCK_ADDR: SFR_RDATA <= key_ff;
            `FM_PKEY_ADDR: SFR_RDATA <= pkey_ff;
            `FM_DATA_ADDR: SFR_RDATA <= data_ff;
            `FM_WPLO_ADDR: SFR_RDATA <= wplo_ff;
            `FM_WPMID_ADDR: SFR_RDATA <= wpmid_ff;
            `FM_RPROT_ADDR: SFR_RDATA <= rprot_ff;
            `FM_ADRL_ADDR: SFR_RDATA <= adrl_ff;
            `FM_ADRH_ADDR: SFR_RDATA <= adrh_ff;
            default: begin
               SFR_RDATA <= 8'h00;
               SFR_HIT <= 1'b0;
            end
         endcase
      end
   end

endmodule // flash_command_controller

// ===== verilog/flash_map.vh
// flash_map.vh: special-function register offsets, reset values, command codes and
// flash geometry for the flash command controller.
// assumes: included by bare name from the design files; definitions only.
//
// Notes on behaviour
// R1: array is 16 kB as 32 pages of 512 bytes; erases act on whole pages.
// R2: byte comes from data register; address from high and low address registers.
// R3: a command executes only while the unlock key register holds 0x3b.
// R4: unlock key returns to its reset value after every flash operation.
// R5: core program counter is held until the requested operation finishes.
// R6: interrupts arriving during an operation are serviced only after it ends.
// R7: timers and peripherals keep running; only execution and interrupts stall.
// R8: code 1 programs the data register into the addressed byte.
// R9: software must erase the target byte before issuing code 1.
// R10: code 2 erases the 512-byte page holding the addressed byte.
// R11: code 3 erases the whole array; user code should not issue it.
// R12: code 4 reads the addressed byte into the data register.
// R13: code 5 erases the addressed page, then programs the addressed byte.
// R14: code 8 commits protection key and protection bits into flash.
// R15: protection update allowed only if protection key matches byte 0x3ffa.
// R16: stored key 0xff skips the comparison and permits the update.
// R17: code 8 writes the protection key into flash, effective only once.
// R18: command, data, address reset to 0x00; keys and protection bits 0xff.
// R19: erased byte reads 0xff; programming clears bits; erase sets them.
// R20: protection enforced only while the last page is write/erase protected.
// R21: read protection per group of four pages; cleared bit protects.
// R22: cleared write/erase bit protects its page; writes and erases blocked.
// R23: codes other than 1, 2, 3, 4, 5, 8 change nothing.
// R24: rejected commands do not stall the core and leave flash unchanged.

`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH

// register offsets in the special-function space
`define FM_CMD_ADDR 8'hb9
`define FM_UNLOCK_ADDR 8'hba
`define FM_PKEY_ADDR 8'hbb
`define FM_DATA_ADDR 8'hbc
`define FM_WPLO_ADDR 8'hbd
`define FM_WPMID_ADDR 8'hbe
`define FM_RPROT_ADDR 8'hbf
`define FM_ADRL_ADDR 8'hc6
`define FM_ADRH_ADDR 8'hc7

// reset values
`define FM_ZERO_RST 8'h00
`define FM_ONES_RST 8'hff

// unlock key and erased byte value
`define FM_UNLOCK_KEY 8'h3b
`define FM_ERASED 8'hff

// command codes
`define FM_OP_PROG 8'h01
`define FM_OP_ERPAGE 8'h02
`define FM_OP_ERALL 8'h03
`define FM_OP_READ 8'h04
`define FM_OP_ERPROG 8'h05
`define FM_OP_PROT 8'h08

// geometry: 14-bit byte address, 9-bit offset in page
`define FM_ADDR_W 14
`define FM_PAGE_BITS 9
`define FM_ARRAY_BYTES 16384
`define FM_PAGE_LAST 14'h01ff
// protection bytes: key, read groups, then four write/erase bytes
`define FM_PROT_BASE 14'h3ffa
`define FM_PROT_BYTES 6
`define FM_PROT_LAST 3'h5

`endif
